// ==== rtl/fsba_map.svh ====
// Constants for the front side bus address-phase host controller.
// Assumes inclusion by bare name from the rtl folder.
`ifndef FSBA_MAP_SVH
`define FSBA_MAP_SVH
// ----------------------------------------
// Address layout
// ----------------------------------------
`define FSBA_ADDR_HI      31
`define FSBA_ADDR_LO      3
`define FSBA_LOW_SPLIT    16
`define FSBA_HIGH_START   17
`define FSBA_A20_BIT      20
`define FSBA_REQ_W        5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSBA_RST_STRAP    29'h0000000
// ----------------------------------------
// Bus clock selection codes
// ----------------------------------------
`define FSBA_BSEL_100     3'h1
`define FSBA_BSEL_133     3'h0
`endif

// ==== rtl/fsba_pkg.sv ====
// Types for the front side bus address-phase host controller.
// Assumes the map header is included; the widths below are written as literals.
`include "fsba_map.svh"
package fsba_pkg;
	typedef enum logic [1:0] {
		FSBA_IDLE,
		FSBA_SUB1,
		FSBA_SUB2
	} fsba_phase_e;

	typedef struct packed {
		fsba_phase_e phase;
		logic        owner;
		logic [28:0] addr;
		logic [4:0]  req;
		logic [28:0] drive;
		logic [4:0]  req_drive;
		logic        ads;
		logic        stb;
		logic        drive_en;
		logic        strap_en;
		logic        priority_bus_request;
		logic        busy;
		logic        prio_done;
		logic        seen;
		logic [28:0] cap_addr;
		logic [4:0]  cap_req;
		logic [3:0]  bpm;
		logic [2:0]  bsel;
		logic        cap_valid;
	} fsba_state_s;
endpackage

// ==== rtl/fsba_host.sv ====
// Host-side (high-priority agent) address phase and arbitration controller.
// Assumes all pins synchronous to mclk_i, which stands in for the bus clock.
// Function
// (R1) Address pins carry bits 31:3 only
// (R2) Sub-phase one address, sub-phase two type
// (R3) Strobe0 latches low bits, strobe1 high
// (R4) Hold straps on address until reset release
// (R5) Device masks bit 20; host observes (here the host drives bit20_mask_in_n_o)
// (R6) Mask asserted only in real mode
// (R7) Mask stable by target-ready of write
// (R8) Address strobe marks valid request
// (R9) Strobe starts decode and checking
// (R10) Block-next-request stalls new issue
// (R11) Device drives breakpoint monitor lines
// (R12) Device stops requests under priority
// (R13) Priority held until own requests done
// (R14) Device requests bus symmetrically
// (R15) Bus select picks 100 or 133 MHz
// (R16) All agents clocked on one bus clock
// (R17) Hash signals are active low
`timescale 1ns/1ps
`include "fsba_map.svh"
module fsba_host #(
	parameter logic [28:0] STRAP_VALUE = `FSBA_RST_STRAP
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        req_valid_i,
	input  wire logic [28:0] req_addr_i,
	input  wire logic [4:0]  req_type_i,
	input  wire logic        locked_i,
	input  wire logic        real_mode_i,
	input  wire logic        mask20_i,
	input  wire logic        io_write_i,
	output logic             req_ready_o,
	output logic             req_done_o,
	output logic [28:0]      addr_n_o,
	output logic [28:0]      addr_n_oe_o,
	input  wire logic [28:0] addr_n_i,
	output logic [4:0]       reqtype_n_o,
	output logic             reqtype_n_oe_o,
	input  wire logic [4:0]  reqtype_n_i,
	output logic             request_valid_strobe_n_o,
	output logic             request_valid_strobe_n_oe_o,
	input  wire logic        request_valid_strobe_n_i,
	output logic [1:0]       addr_source_strobes_n_o,
	output logic             addr_source_strobes_n_oe_o,
	input  wire logic [1:0]  addr_source_strobes_n_i,
	output logic             priority_bus_request_n_o,
	input  wire logic        block_next_request_n_i,
	input  wire logic        symmetric_bus_request_n_i,
	input  wire logic [3:0]  breakpoint_monitor_out_n_i,
	input  wire logic [2:0]  bus_freq_select_i,
	output logic             bit20_mask_in_n_o,
	output logic             target_ready_n_o,
	output logic [28:0]      snoop_addr_o,
	output logic [4:0]       snoop_type_o,
	output logic             snoop_valid_o,
	output logic [3:0]       bpm_o,
	output logic [2:0]       bsel_o,
	output logic             dev_req_o
);
	fsba_pkg::fsba_state_s st;
	fsba_pkg::fsba_state_s next_st;
	logic                  stall;
	logic                  can_issue;

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	assign stall     = ~block_next_request_n_i; // [R10] [R17]
	assign can_issue = (st.phase == fsba_pkg::FSBA_IDLE) && !stall && !st.strap_en;
	assign req_ready_o = can_issue && st.priority_bus_request && !st.busy;
	assign req_done_o  = st.prio_done;

	always_comb begin
		next_st = st;
		next_st.strap_en  = 1'b0;
		next_st.prio_done = 1'b0;
		next_st.ads       = 1'b0;
		next_st.seen      = 1'b0;
		next_st.bpm  = ~breakpoint_monitor_out_n_i; // [R11]
		next_st.bsel = bus_freq_select_i; // [R15]
		// Priority asserted whenever work is pending; released after done
		if (req_valid_i && !st.priority_bus_request && !st.busy)
			next_st.priority_bus_request = 1'b1;
		unique case (st.phase)
			fsba_pkg::FSBA_IDLE: begin
				next_st.drive_en = 1'b0;
				if (req_ready_o && req_valid_i) begin
					next_st.phase     = fsba_pkg::FSBA_SUB1;
					next_st.busy      = 1'b1;
					next_st.drive     = req_addr_i; // [R1] [R2]
					next_st.req_drive = req_type_i;
					next_st.ads       = 1'b1; // [R8]
					next_st.stb       = 1'b1;
					next_st.drive_en  = 1'b1;
					next_st.addr      = req_addr_i;
					next_st.req       = req_type_i;
				end
			end
			fsba_pkg::FSBA_SUB1: begin
				// Second sub-phase reuses the address pins for type info
				next_st.phase = fsba_pkg::FSBA_SUB2;
				next_st.drive = {24'h000000, st.req}; // [R2]
				next_st.stb   = 1'b0;
			end
			fsba_pkg::FSBA_SUB2: begin
				next_st.phase     = fsba_pkg::FSBA_IDLE;
				next_st.drive_en  = 1'b0;
				next_st.busy      = 1'b0;
				next_st.prio_done = 1'b1;
				// Release priority once no further request waits, unless locked_i holds it
				if (!req_valid_i || locked_i)
					next_st.priority_bus_request = locked_i; // [R13]
			end
			default: next_st.phase = fsba_pkg::FSBA_IDLE;
		endcase
		// Observe any request from the device
		if (!request_valid_strobe_n_i && !st.drive_en) begin
			next_st.seen     = 1'b1; // [R9]
			next_st.cap_addr = ~addr_n_i; // [R3]
			next_st.cap_req  = ~reqtype_n_i;
		end
		// Valid follows the capture by one cycle, so the captured words have settled
		next_st.cap_valid = st.seen;
	end

	always_ff @(posedge mclk_i) begin // [R16]
		if (rst_i) begin
			st           <= '0;
			st.phase     <= fsba_pkg::FSBA_IDLE;
			st.strap_en  <= 1'b1; // [R4]
			st.drive     <= STRAP_VALUE;
			st.drive_en  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Pins (active low on the wire)
	// ----------------------------------------
	assign addr_n_o    = ~st.drive; // [R17]
	assign addr_n_oe_o = {29{st.drive_en}};
	assign reqtype_n_o    = ~st.req_drive;
	assign reqtype_n_oe_o = st.drive_en && (st.phase == fsba_pkg::FSBA_SUB1);
	assign request_valid_strobe_n_o    = ~st.ads;
	assign request_valid_strobe_n_oe_o = st.drive_en && !st.strap_en;
	assign addr_source_strobes_n_o    = {2{~st.stb}}; // [R3]
	assign addr_source_strobes_n_oe_o = st.drive_en && !st.strap_en;
	assign priority_bus_request_n_o = ~st.priority_bus_request; // [R12]
	// Mask only honoured in real mode; driven continuously, independent of target ready
	assign bit20_mask_in_n_o = ~(mask20_i && real_mode_i); // [R6] [R5]
	assign target_ready_n_o  = ~(io_write_i && st.seen); // [R7]
	assign snoop_addr_o  = st.cap_addr;
	assign snoop_type_o  = st.cap_req;
	assign snoop_valid_o = st.cap_valid;
	assign bpm_o    = st.bpm;
	assign bsel_o   = st.bsel;
	assign dev_req_o = ~symmetric_bus_request_n_i; // [R14]

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_issue;
		st.phase == fsba_pkg::FSBA_SUB1;
	endsequence
	sequence s_two_phase;
		st.phase == fsba_pkg::FSBA_SUB2 ##1 st.phase == fsba_pkg::FSBA_IDLE;
	endsequence
	property p_two_phase;
		@(posedge mclk_i) disable iff (rst_i) s_issue |-> ##1 s_two_phase;
	endproperty
	a_two_phase: assert property (p_two_phase) else $error("sub-phases broken"); // [R2]
	property p_stall;
		@(posedge mclk_i) disable iff (rst_i) stall |-> !req_ready_o;
	endproperty
	a_stall: assert property (p_stall) else $error("issued under stall"); // [R10]
	property p_ads;
		@(posedge mclk_i) disable iff (rst_i)
			s_issue |-> !request_valid_strobe_n_o && request_valid_strobe_n_oe_o;
	endproperty
	a_ads: assert property (p_ads) else $error("strobe missing"); // [R8]
	property p_strap;
		@(posedge mclk_i) $fell(rst_i) |-> addr_n_o == ~STRAP_VALUE && addr_n_oe_o[0];
	endproperty
	a_strap: assert property (p_strap) else $error("strap not held"); // [R4]
	property p_prio;
		@(posedge mclk_i) disable iff (rst_i) s_issue |-> !priority_bus_request_n_o[*2];
	endproperty
	a_prio: assert property (p_prio) else $error("priority dropped early"); // [R13]
	property p_type;
		@(posedge mclk_i) disable iff (rst_i)
			s_issue |=> addr_n_o[4:0] == ~$past(st.req, 1);
	endproperty
	a_type: assert property (p_type) else $error("type not on address"); // [R2]
	property p_snoop;
		@(posedge mclk_i) disable iff (rst_i) st.seen |=> snoop_valid_o;
	endproperty
	a_snoop: assert property (p_snoop) else $error("capture lost"); // [R9]
	property p_mask;
		@(posedge mclk_i) disable iff (rst_i) !real_mode_i |-> bit20_mask_in_n_o;
	endproperty
	a_mask: assert property (p_mask) else $error("mask outside real mode"); // [R6]
endmodule

// ==== dv/fsba_dev.sv ====
// Device-side model of the bus agent facing the host address-phase controller.
// Assumes the bench resolves every shared pin to its wire level first.
`timescale 1ns/1ps
module fsba_dev (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [28:0] addr_n_i,
	input  wire logic [4:0]  reqtype_n_i,
	input  wire logic        ads_n_i,
	input  wire logic [1:0]  stb_n_i,
	input  wire logic        prio_n_i,
	input  wire logic        stall_i,
	input  wire logic        want_i,
	input  wire logic [3:0]  bpm_i,
	input  wire logic [2:0]  freq_i,
	output logic             bnr_n_o,
	output logic             br_n_o,
	output logic [3:0]       bpm_n_o,
	output logic [2:0]       bsel_o,
	output logic [28:0]      strap_o,
	output logic [28:0]      cap_addr_o,
	output logic [4:0]       cap_type_o
);
	// ----------------------------------------
	// Arbitration and sideband pins
	// ----------------------------------------
	assign bnr_n_o = ~stall_i;
	assign br_n_o  = ~(want_i & prio_n_i);
	assign bpm_n_o = ~bpm_i;
	assign bsel_o  = freq_i;
	// ----------------------------------------
	// Capture, one strobe per address half
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (rst_i)
			strap_o <= ~addr_n_i;
		if (!ads_n_i && !stb_n_i[0]) begin
			cap_addr_o[13:0] <= ~addr_n_i[13:0];
			cap_type_o       <= ~reqtype_n_i;
		end
		if (!ads_n_i && !stb_n_i[1])
			cap_addr_o[28:14] <= ~addr_n_i[28:14];
	end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the host address-phase controller.
// Assumes released bus pins are terminated high, so they read deasserted.
`timescale 1ns/1ps
`include "fsba_map.svh"
module tb;
	localparam logic [28:0] STRAP = 29'h0123abc;
	logic mclk_i, rst_i, req_valid_i, real_mode_i, mask20_i, req_ready_o, req_done_o;
	logic [28:0] req_addr_i, addr_n_o, addr_n_oe_o, addr_w, strap, cap_addr;
	logic [4:0] req_type_i, reqtype_n_o, req_w, cap_type;
	logic reqtype_n_oe_o, ads_n, ads_oe, ads_w, stb_oe, prio_n, mask_n, dev_req_o;
	logic [1:0] stb_n, stb_w;
	logic stall, want, bnr_n, br_n, target_ready_n, snp_v;
	logic [3:0] bpm_v, bpm_n, bpm_o;
	logic [2:0] freq, bsel, bsel_o;
	int err_count, checks_done, i;
	assign addr_w = (addr_n_oe_o & addr_n_o) | ~addr_n_oe_o;
	assign req_w  = reqtype_n_oe_o ? reqtype_n_o : 5'h1f;
	assign ads_w  = ads_oe ? ads_n : 1'h1;
	assign stb_w  = stb_oe ? stb_n : 2'h3;
	fsba_host #(.STRAP_VALUE(STRAP)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.req_valid_i(req_valid_i), .req_addr_i(req_addr_i), .req_type_i(req_type_i),
		.locked_i(1'h0), .real_mode_i(real_mode_i), .mask20_i(mask20_i), .io_write_i(1'h0),
		.req_ready_o(req_ready_o), .req_done_o(req_done_o), .addr_n_o(addr_n_o),
		.addr_n_oe_o(addr_n_oe_o), .addr_n_i(addr_w), .reqtype_n_o(reqtype_n_o),
		.reqtype_n_oe_o(reqtype_n_oe_o), .reqtype_n_i(req_w), .request_valid_strobe_n_o(ads_n),
		.request_valid_strobe_n_oe_o(ads_oe), .request_valid_strobe_n_i(ads_w),
		.addr_source_strobes_n_o(stb_n), .addr_source_strobes_n_oe_o(stb_oe),
		.addr_source_strobes_n_i(stb_w), .priority_bus_request_n_o(prio_n),
		.block_next_request_n_i(bnr_n), .symmetric_bus_request_n_i(br_n),
		.breakpoint_monitor_out_n_i(bpm_n), .bus_freq_select_i(bsel),
		.bit20_mask_in_n_o(mask_n), .target_ready_n_o(target_ready_n), .snoop_addr_o(),
		.snoop_type_o(), .snoop_valid_o(snp_v), .bpm_o(bpm_o), .bsel_o(bsel_o),
		.dev_req_o(dev_req_o));
	fsba_dev u_dev (.mclk_i(mclk_i), .rst_i(rst_i), .addr_n_i(addr_w), .reqtype_n_i(req_w),
		.ads_n_i(ads_w), .stb_n_i(stb_w), .prio_n_i(prio_n), .stall_i(stall), .want_i(want),
		.bpm_i(bpm_v), .freq_i(freq), .bnr_n_o(bnr_n), .br_n_o(br_n), .bpm_n_o(bpm_n),
		.bsel_o(bsel), .strap_o(strap), .cap_addr_o(cap_addr), .cap_type_o(cap_type));
	initial begin
		mclk_i = 0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Stall overlaps the wait for priority, so ready must stay low throughout
	task automatic req(input logic [28:0] a, input logic [4:0] t, input int st);
		int n;
		@(posedge mclk_i);
		stall <= (st > 0);
		{req_valid_i, req_addr_i, req_type_i} <= {1'h1, a, t};
		for (n = 0; n < st; n++) begin
			@(negedge mclk_i);
			chk("ready under stall", req_ready_o, 0);
		end
		@(posedge mclk_i);
		stall <= 0;
		@(negedge mclk_i);
		for (n = 0; n < 20 && req_ready_o !== 1'h1; n++)
			@(negedge mclk_i);
		if (n == 20) begin
			err_count++;
			test_done();
		end
		chk("priority held", prio_n, 0);
		@(posedge mclk_i);
		req_valid_i <= 0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		chk("done", req_done_o, 1);
		chk("address", cap_addr, a);
		chk("type", cap_type, t);
	endtask
	initial begin
		{rst_i, req_valid_i, real_mode_i, mask20_i, stall, want} = 6'h20;
		{req_addr_i, req_type_i, bpm_v, freq, err_count, checks_done} = '0;
		void'($urandom(4444));
		repeat (8) @(posedge mclk_i);
		rst_i <= 0;
		@(negedge mclk_i);
		chk("strap", strap, STRAP);
		for (i = 0; i < 4; i++) begin
			@(posedge mclk_i);
			{real_mode_i, mask20_i} <= i[1:0];
			@(negedge mclk_i);
			chk("mask pin", mask_n, !(i[0] && i[1]));
		end
		for (i = 0; i < 10; i++) begin
			req(i < 2 ? {29{i[0]}} : 29'($urandom), 5'($urandom), i == 3 ? 3 : 0);
			@(posedge mclk_i);
			want  <= 1'($urandom);
			bpm_v <= 4'($urandom);
			freq  <= i[0] ? `FSBA_BSEL_100 : `FSBA_BSEL_133;
			repeat (3) @(posedge mclk_i);
			@(negedge mclk_i);
			chk("monitor", bpm_o, bpm_v);
			chk("bus select", bsel_o, freq);
			chk("device request", dev_req_o, want && prio_n);
			chk("no self snoop", snp_v, 0);
			chk("target ready idle", target_ready_n, 1);
		end
		test_done();
	end
endmodule
